// >>> design/general_feature_control_register.sv
// What this block does
// - register at 84h, 32 bits, reset 00030019h
// - only global reset clears the fields
// - bit 31 sets media power pin polarity
// - bit 30 picks smart-card interface style
// - style bit holds 1 only with arrangement 01b
// - one write may set both arrangement and style
// - route select set makes style bit ineffective
// - bit 29 shortens card type query time
// - bit 28 drives I/O limit bit 0
// - bit 27 drives I/O base bit 0
// - bit 26 names power switch type
// - bits 25-24 set media socket arrangement
// - bits 23-21 disable smart-card, SD, media
// - bit 20 is plain storage, no effect
// - bits 17-16 set arbitration priority
// - bits 7-0 set debounce in 2 ms
// - bit 9 routes smart-card logic
module general_feature_control_register
#(
  parameter int DEB_UNIT   = gfc_pkg::DEB_UNIT_CYC,
  parameter int QUERY_LONG = gfc_pkg::QUERY_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire gfc_pkg::cfg_req_t cfg_req_in,
  output logic [31:0]            cfg_rdata_out,
  output logic                   cfg_hit_out,
  output gfc_pkg::ctrl_t         ctrl_out,
  output logic                   io_base_bit0_out,
  output logic                   io_limit_bit0_out,
  input  wire logic              media_power_req_a_in,
  input  wire logic              media_power_req_b_in,
  output logic                   media_power_out_a,
  output logic                   media_power_out_b,
  output logic                   smartcard_legacy_style_out,
  input  wire logic              query_start_in,
  output logic                   query_done_out,
  input  wire logic              card_detect_raw_in,
  output logic                   card_present_out
);
  import gfc_pkg::*;

  // ------------------------------------------------------------
  // reset synchroniser (reset_n_in stands for the global reset)
  // ------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  // release through two flops so no flop leaves reset mid-edge
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // configuration access decode
  // ------------------------------------------------------------
  logic [31:0] gfc_q;
  logic [31:0] gfc_d;
  logic [31:0] be_mask;
  logic [31:0] merged;
  logic [31:0] rdata_d;
  wire         gfc_sel   = (cfg_req_in.addr == GFC_OFFSET) && (cfg_req_in.func == GLOBAL_FUNC);
  wire         gfc_write = cfg_req_in.wr && gfc_sel;
  wire         gfc_read  = cfg_req_in.rd && gfc_sel;
  wire         base_sel  = cfg_req_in.rd &&
                           ((cfg_req_in.addr == IO_BASE_A_OFF) || (cfg_req_in.addr == IO_BASE_B_OFF));
  wire         limit_sel = cfg_req_in.rd &&
                           ((cfg_req_in.addr == IO_LIMIT_A_OFF) || (cfg_req_in.addr == IO_LIMIT_B_OFF));

  // byte lanes expanded to a bit mask
  assign be_mask = {{8{cfg_req_in.be[3]}}, {8{cfg_req_in.be[2]}},
                    {8{cfg_req_in.be[1]}}, {8{cfg_req_in.be[0]}}};
  assign merged  = ((cfg_req_in.wdata & be_mask) | (gfc_q & ~be_mask)) & GFC_RW_MASK;

  // style bit is judged against the merged arrangement, so a
  // single write of both fields keeps both (no ordering hazard)
  always_comb
  begin
    gfc_d = gfc_q;
    if (gfc_write)
      gfc_d = merged;
    if (gfc_d[ARR_LSB +: 2] != ARR_TWO_IN_ONE)
      gfc_d[STYLE_BIT] = 1'b0;
  end

  // storage; bit 20 is kept but feeds nothing
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
      gfc_q <= GFC_RESET;
    else
      gfc_q <= gfc_d;
  end

  // ------------------------------------------------------------
  // read data, registered
  // ------------------------------------------------------------
  // the I/O base/limit bit 0 comes from here; other bits elsewhere
  assign rdata_d = gfc_read  ? gfc_q :
                   base_sel  ? {31'h0, gfc_q[BASE_BIT]} :
                   limit_sel ? {31'h0, gfc_q[LIMIT_BIT]} :
                   32'h0;

  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cfg_rdata_out <= 32'h0;
      cfg_hit_out   <= 1'b0;
    end
    else
    begin
      cfg_rdata_out <= rdata_d;
      cfg_hit_out   <= gfc_read;
    end
  end

  // ------------------------------------------------------------
  // decoded controls to the rest of the device
  // ------------------------------------------------------------
  ctrl_t ctrl_d;
  always_comb
  begin
    ctrl_d.media_power_pin_polarity = gfc_q[POL_BIT];
    ctrl_d.smartcard_style_select   = gfc_q[STYLE_BIT];
    ctrl_d.fast_query_select        = gfc_q[FAST_BIT];
    ctrl_d.power_switch_type_select = gfc_q[SWITCH_BIT];
    ctrl_d.media_socket_arrangement = gfc_q[ARR_LSB +: 2];
    ctrl_d.smartcard_function_off   = gfc_q[SC_OFF_BIT];
    ctrl_d.sd_host_function_off     = gfc_q[SD_OFF_BIT];
    ctrl_d.media_function_off       = gfc_q[FM_OFF_BIT];
    ctrl_d.smartcard_route_select   = gfc_q[ROUTE_BIT];
    ctrl_d.arbitration_priority     = arb_mode_t'(gfc_q[ARB_LSB +: 2]);
  end

  // pins: polarity xnor; style ignored when routed to socket adapter
  wire pin_a_d = (media_power_req_a_in & ~gfc_q[FM_OFF_BIT]) ~^ gfc_q[POL_BIT];
  wire pin_b_d = (media_power_req_b_in & ~gfc_q[FM_OFF_BIT]) ~^ gfc_q[POL_BIT];
  wire style_d = gfc_q[STYLE_BIT] & ~gfc_q[ROUTE_BIT] & ~gfc_q[SC_OFF_BIT];

  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_out                   <= '0;
      io_base_bit0_out           <= 1'b0;
      io_limit_bit0_out          <= 1'b0;
      media_power_out_a          <= 1'b1; // inactive for active-low default
      media_power_out_b          <= 1'b1;
      smartcard_legacy_style_out <= 1'b0;
    end
    else
    begin
      ctrl_out                   <= ctrl_d;
      io_base_bit0_out           <= gfc_q[BASE_BIT];
      io_limit_bit0_out          <= gfc_q[LIMIT_BIT];
      media_power_out_a          <= pin_a_d;
      media_power_out_b          <= pin_b_d;
      smartcard_legacy_style_out <= style_d;
    end
  end

  // ------------------------------------------------------------
  // card type query timer, short in fast mode
  // ------------------------------------------------------------
  localparam int QW = $clog2(QUERY_LONG + 1);
  wire [QW-1:0] query_len = gfc_q[FAST_BIT] ? QW'(QUERY_FAST_CYC) : QW'(QUERY_LONG);
  logic         query_done_w;

  tick_timer #(
    .WIDTH (QW)
  ) tick_timer_inst (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_q),
    .load_in  (query_start_in & ~gfc_q[FM_OFF_BIT]),
    .count_in (query_len),
    .done_out (query_done_w)
  );

  // ------------------------------------------------------------
  // card detect debounce, units of 2 ms
  // ------------------------------------------------------------
  logic present_w;

  card_detect_filter #(
    .UNIT_CYC (DEB_UNIT)
  ) card_detect_filter_inst (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_q),
    .limit_in   (gfc_q[DEB_LSB +: 8]),
    .raw_in     (card_detect_raw_in),
    .stable_out (present_w)
  );

  // outputs straight from flops
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      query_done_out   <= 1'b0;
      card_present_out <= 1'b0;
    end
    else
    begin
      query_done_out   <= query_done_w;
      card_present_out <= present_w & ~gfc_q[FM_OFF_BIT];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_style_needs_arr: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    gfc_q[STYLE_BIT] |-> gfc_q[ARR_LSB +: 2] == ARR_TWO_IN_ONE)
    else $error("style bit set without two-in-one arrangement");

  a_joint_write: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (gfc_write && cfg_req_in.be[3] && cfg_req_in.wdata[STYLE_BIT]
     && cfg_req_in.wdata[ARR_LSB +: 2] == ARR_TWO_IN_ONE) |=> gfc_q[STYLE_BIT])
    else $error("joint write lost style bit");

  a_byte_enable: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (gfc_write && !cfg_req_in.be[0]) |=> gfc_q[7:0] == $past(gfc_q[7:0]))
    else $error("disabled byte lane changed");

  a_read_back: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    gfc_read |=> cfg_hit_out && cfg_rdata_out == $past(gfc_q))
    else $error("read data mismatch");

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    gfc_q[15:11] == 5'h0)
    else $error("reserved bits not zero");

  a_pin_polarity: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $past(rst_n_q) |-> media_power_out_a ==
      ($past(media_power_req_a_in & ~gfc_q[FM_OFF_BIT]) ~^ $past(gfc_q[POL_BIT])))
    else $error("power pin polarity wrong");

  a_route_masks: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    gfc_q[ROUTE_BIT] |=> !smartcard_legacy_style_out)
    else $error("style active while routed to socket");

  a_io_bits: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    ##1 (io_limit_bit0_out == $past(gfc_q[LIMIT_BIT])) && (io_base_bit0_out == $past(gfc_q[BASE_BIT])))
    else $error("io base or limit bit 0 wrong");

  // ------------------------------------------------------------
  // checks on pins, decoded fields and refused accesses
  // ------------------------------------------------------------
  a_pin_b_polarity: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $past(rst_n_q) |-> media_power_out_b ==
      ($past(media_power_req_b_in & ~gfc_q[FM_OFF_BIT]) ~^ $past(gfc_q[POL_BIT])))
    else $error("second power pin polarity wrong");

  // a switched-off media function must leave both pins idle
  a_media_off_pins: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    gfc_q[FM_OFF_BIT] |=> (media_power_out_a == !$past(gfc_q[POL_BIT]))
                          && (media_power_out_b == !$past(gfc_q[POL_BIT])))
    else $error("power pin active while media function off");

  a_media_off_present: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    gfc_q[FM_OFF_BIT] |=> !card_present_out)
    else $error("card present while media function off");

  a_legacy_style: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $past(rst_n_q) |-> smartcard_legacy_style_out ==
      $past(gfc_q[STYLE_BIT] && !gfc_q[ROUTE_BIT] && !gfc_q[SC_OFF_BIT]))
    else $error("legacy style output wrong");

  a_arrangement_follows: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $past(rst_n_q) |-> ctrl_out.media_socket_arrangement == $past(gfc_q[ARR_LSB +: 2]))
    else $error("socket arrangement output wrong");

  a_arb_follows: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    $past(rst_n_q) |-> 2'(ctrl_out.arbitration_priority) == $past(gfc_q[ARB_LSB +: 2]))
    else $error("arbitration priority output wrong");

  // refused places: another function or an unmapped offset
  a_refused_write: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (cfg_req_in.wr && cfg_req_in.func != GLOBAL_FUNC) |=> $stable(gfc_q))
    else $error("write through another function changed the register");

  a_unmapped_read: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    (cfg_req_in.rd && !gfc_sel && !base_sel && !limit_sel) |=> !cfg_hit_out && cfg_rdata_out == 32'h0)
    else $error("unmapped read returned data");

  a_io_base_read: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    base_sel |=> cfg_rdata_out == {31'h0, $past(gfc_q[BASE_BIT])})
    else $error("io base read bit 0 wrong");

  a_io_limit_read: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    limit_sel |=> cfg_rdata_out == {31'h0, $past(gfc_q[LIMIT_BIT])})
    else $error("io limit read bit 0 wrong");

  // done must stay a single-cycle pulse for the consumer
  a_done_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_q)
    query_done_out |=> !query_done_out)
    else $error("query done held longer than one cycle");

endmodule : general_feature_control_register

// >>> design/gfc_pkg.sv
package gfc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  GFC_OFFSET      = 8'h84;
  localparam logic [7:0]  IO_BASE_A_OFF   = 8'h2C;
  localparam logic [7:0]  IO_BASE_B_OFF   = 8'h34;
  localparam logic [7:0]  IO_LIMIT_A_OFF  = 8'h30;
  localparam logic [7:0]  IO_LIMIT_B_OFF  = 8'h38;
  localparam logic [31:0] GFC_RESET       = 32'h0003_0019;
  localparam logic [2:0]  GLOBAL_FUNC     = 3'h0;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int POL_BIT      = 31;
  localparam int STYLE_BIT    = 30;
  localparam int FAST_BIT     = 29;
  localparam int LIMIT_BIT    = 28;
  localparam int BASE_BIT     = 27;
  localparam int SWITCH_BIT   = 26;
  localparam int ARR_LSB      = 24;
  localparam int SC_OFF_BIT   = 23;
  localparam int SD_OFF_BIT   = 22;
  localparam int FM_OFF_BIT   = 21;
  localparam int ROUTE_BIT    = 9;
  localparam int ARB_LSB      = 16;
  localparam int DEB_LSB      = 0;
  localparam logic [1:0] ARR_TWO_IN_ONE = 2'h1;

  // writable bits: 31..16, 10..0; 15..11 reserved read zero
  localparam logic [31:0] GFC_RW_MASK = 32'hFFFF_07FF;

  // ------------------------------------------------------------
  // timing: debounce unit and query time
  // ------------------------------------------------------------
  localparam int CLK_MHZ          = 50;
  localparam int DEB_UNIT_US      = 2000;
  localparam int DEB_UNIT_CYC     = DEB_UNIT_US * CLK_MHZ;
  localparam int QUERY_US         = 1000;
  localparam int QUERY_CYC        = QUERY_US * CLK_MHZ;
  localparam int QUERY_FAST_CYC   = 16;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ARB_1394  = 2'b00,
    ARB_CBUS  = 2'b01,
    ARB_MEDIA = 2'b10,
    ARB_RR    = 2'b11
  } arb_mode_t;

  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [2:0]  func;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed
  {
    logic        media_power_pin_polarity;
    logic        smartcard_style_select;
    logic        fast_query_select;
    logic        power_switch_type_select;
    logic [1:0]  media_socket_arrangement;
    logic        smartcard_function_off;
    logic        sd_host_function_off;
    logic        media_function_off;
    logic        smartcard_route_select;
    arb_mode_t   arbitration_priority;
  } ctrl_t;

endpackage : gfc_pkg

// >>> design/tick_timer.sv
// ------------------------------------------------------------
// reloadable down counter, pulses done_out when it reaches zero
// ------------------------------------------------------------
module tick_timer #(
  parameter int WIDTH = 24
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] count_in,
  output logic                  done_out
);
  logic [WIDTH-1:0] cnt_q;
  logic             run_q;

  // count down while running; load restarts
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q    <= '0;
      run_q    <= 1'b0;
      done_out <= 1'b0;
    end
    else if (load_in)
    begin
      cnt_q    <= count_in;
      run_q    <= 1'b1;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= run_q && (cnt_q == '0);
      if (run_q && cnt_q == '0)
        run_q <= 1'b0;
      else if (run_q)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : tick_timer

// >>> design/card_detect_filter.sv
// ------------------------------------------------------------
// debounce: input must hold steady for limit_in units
// ------------------------------------------------------------
module card_detect_filter #(
  parameter int UNIT_CYC = 100000
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] limit_in,
  input  wire logic       raw_in,
  output logic            stable_out
);
  logic [$clog2(UNIT_CYC+1)-1:0] pre_q;
  logic [7:0]                    units_q;
  logic                          last_q;
  wire                           unit_tick = (pre_q == '0);

  // restart counting on any change of the raw level
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pre_q      <= '0;
      units_q    <= '0;
      last_q     <= 1'b0;
      stable_out <= 1'b0;
    end
    else
    begin
      last_q <= raw_in;
      if (raw_in != last_q)
      begin
        pre_q   <= ($clog2(UNIT_CYC+1))'(UNIT_CYC - 1);
        units_q <= '0;
      end
      else
      begin
        pre_q <= unit_tick ? ($clog2(UNIT_CYC+1))'(UNIT_CYC - 1) : pre_q - 1'b1;
        if (unit_tick && units_q != 8'hFF)
          units_q <= units_q + 8'h01;
        if (units_q >= limit_in)
          stable_out <= last_q;
      end
    end
  end
endmodule : card_detect_filter

// >>> dv/general_feature_control_register_tb_top.sv
module general_feature_control_register_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gfc_pkg::*;

  // ----------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------
  logic        clk_in;
  logic        reset_n_in;
  cfg_req_t    req;
  logic [31:0] rdata;
  logic        hit;
  ctrl_t       ctrl;
  logic        iob, iol, pra, prb, poa, pob, scl, qs, qd, cdr, cp;
  logic [31:0] m, rs, d, x;
  logic        h;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;

  // short counts keep the query and debounce runs brief
  general_feature_control_register #(.DEB_UNIT(4), .QUERY_LONG(40)) general_feature_control_register_inst (
    .clk_in                     (clk_in),
    .reset_n_in                 (reset_n_in),
    .cfg_req_in                 (req),
    .cfg_rdata_out              (rdata),
    .cfg_hit_out                (hit),
    .ctrl_out                   (ctrl),
    .io_base_bit0_out           (iob),
    .io_limit_bit0_out          (iol),
    .media_power_req_a_in       (pra),
    .media_power_req_b_in       (prb),
    .media_power_out_a          (poa),
    .media_power_out_b          (pob),
    .smartcard_legacy_style_out (scl),
    .query_start_in             (qs),
    .query_done_out             (qd),
    .card_detect_raw_in         (cdr),
    .card_present_out           (cp)
  );

  // 50 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // hang guard, far above the expected run length
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs

  // byte merge, reserved bits dropped, style bit only with two-in-one
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] w, logic [3:0] be);
    logic [31:0] r;
    for (int i = 0; i < 4; i++) r[8*i+:8] = be[i] ? w[8*i+:8] : o[8*i+:8];
    r = r & GFC_RW_MASK;
    if (r[25:24] != ARR_TWO_IN_ONE) r[30] = 1'b0;
    return r;
  endfunction : merge

  function automatic ctrl_t exp_ctrl(logic [31:0] v);
    ctrl_t c;
    c.media_power_pin_polarity = v[31];
    c.smartcard_style_select   = v[30];
    c.fast_query_select        = v[29];
    c.power_switch_type_select = v[26];
    c.media_socket_arrangement = v[25:24];
    c.smartcard_function_off   = v[23];
    c.sd_host_function_off     = v[22];
    c.media_function_off       = v[21];
    c.smartcard_route_select   = v[9];
    c.arbitration_priority     = arb_mode_t'(v[17:16]);
    return c;
  endfunction : exp_ctrl

  task automatic stop_test();
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask : chk

  task automatic chkb(string n, logic s, logic e);
    chk(n, {31'h0, s}, {31'h0, e});
  endtask : chkb

  // one configuration cycle each; request held for exactly one edge
  task automatic wr(logic [7:0] a, logic [2:0] f, logic [3:0] be, logic [31:0] w);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, func: f, addr: a, be: be, wdata: w};
    @(posedge clk_in);
    req <= '0;
    if (a == GFC_OFFSET && f == GLOBAL_FUNC) m = merge(m, w, be);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [2:0] f, output logic [31:0] dv, output logic hv);
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, func: f, addr: a, be: 4'hF, wdata: 32'h0};
    @(posedge clk_in);
    req <= '0;
    #1;
    dv = rdata;
    hv = hit;
  endtask : rd

  task automatic rb();
    rd(GFC_OFFSET, GLOBAL_FUNC, d, h);
    chk("reg", d, m);
    chkb("hit", h, 1'b1);
    chk("ctrl", 32'(ctrl), 32'(exp_ctrl(m)));
  endtask : rb

  // pin side: fresh random power requests, then both power pins, legacy style and I/O bit 0 outputs
  task automatic outs();
    logic [31:0] r;
    r = xs();
    @(posedge clk_in);
    pra <= r[0];
    prb <= r[1];
    repeat (3) @(posedge clk_in);
    #1;
    chkb("pwr_a", poa, m[21] ? ~m[31] : ~(pra ^ m[31]));
    chkb("pwr_b", pob, m[21] ? ~m[31] : ~(prb ^ m[31]));
    chkb("legacy", scl, m[30] & ~m[9] & ~m[23]);
    chkb("iobase", iob, m[27]);
    chkb("iolimit", iol, m[28]);
  endtask : outs

  task automatic qtest(logic f, int lo, int hi);
    int n;
    n = 0;
    wr(GFC_OFFSET, GLOBAL_FUNC, 4'hF, {2'b0, f, 29'h0003_0019});
    @(posedge clk_in);
    qs <= 1'b1;
    @(posedge clk_in);
    qs <= 1'b0;
    while (n < 100)
    begin
      @(posedge clk_in);
      #1;
      n++;
      if (qd === 1'b1) break;
    end
    chkb("query", n >= lo && n <= hi, 1'b1);
  endtask : qtest

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    logic [7:0] offs [4];
    offs = '{IO_BASE_A_OFF, IO_BASE_B_OFF, IO_LIMIT_A_OFF, IO_LIMIT_B_OFF};
    req = '0;
    {pra, prb, qs, cdr} = 4'h0;
    reset_n_in = 1'b0;
    rs = 32'h55;
    m = GFC_RESET;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rb();
    outs();
    // style bit and two-in-one arrive in one write
    wr(GFC_OFFSET, GLOBAL_FUNC, 4'hF, 32'h4103_0019);
    rb();
    outs();
    wr(GFC_OFFSET, GLOBAL_FUNC, 4'hF, 32'h4203_0019);
    rb();
    wr(GFC_OFFSET, GLOBAL_FUNC, 4'hF, 32'h4103_0219);
    rb();
    outs();
    for (int i = 0; i < 4; i++)
    begin
      wr(GFC_OFFSET, GLOBAL_FUNC, 4'hF, {6'h0, 2'(i), 6'h0, 2'(i), 16'h0019});
      rb();
      outs();
    end
    repeat (40)
    begin
      x = xs();
      wr(GFC_OFFSET, GLOBAL_FUNC, 4'(xs()), x);
      rb();
      outs();
    end
    // refused places leave the register alone
    wr(GFC_OFFSET, 3'h1, 4'hF, 32'hFFFF_FFFF);
    wr(8'h88, GLOBAL_FUNC, 4'hF, 32'hFFFF_FFFF);
    rb();
    rd(8'h88, GLOBAL_FUNC, d, h);
    chk("unmapped", d, 32'h0);
    chkb("nohit", h, 1'b0);
    rd(GFC_OFFSET, 3'h1, d, h);
    chk("func1", d, 32'h0);
    chkb("func1_hit", h, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      wr(GFC_OFFSET, GLOBAL_FUNC, 4'hF, k ? 32'h0803_0019 : 32'h1003_0019);
      for (int j = 0; j < 4; j++)
      begin
        rd(offs[j], GLOBAL_FUNC, d, h);
        chk("bit0", d, {31'h0, (j < 2) ? m[27] : m[28]});
      end
    end
    qtest(1'b1, 15, 20);
    qtest(1'b0, 39, 44);
    // debounce of two units, written through byte 0 alone
    wr(GFC_OFFSET, GLOBAL_FUNC, 4'h1, 32'hFFFF_FF02);
    rb();
    @(posedge clk_in);
    cdr <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chkb("early", cp, 1'b0);
    repeat (40) @(posedge clk_in);
    #1;
    chkb("present", cp, 1'b1);
    // second reset in mid-run restores the defaults
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chkb("rst_pwr", poa, 1'b1);
    chkb("rst_pwr_b", pob, 1'b1);
    chkb("rst_present", cp, 1'b0);
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    m = GFC_RESET;
    repeat (3) @(posedge clk_in);
    rb();
    stop_test();
  end

endmodule : general_feature_control_register_tb_top
